// ===== hdl/timer2_control.sv
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "timer2_cfg.svh"

module timer2_control
  import timer2_pkg::*;
(
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic [3:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic [31:0]      AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  input  wire logic        EXTERNAL_TIMER_CLOCK_PIN_IN,
  input  wire logic        IDLE_MODE_IN,
  input  wire logic        PERIOD_MATCH_IN,
  input  wire logic        UPPER_MATCH_IN,
  output logic             LOWER_TICK_OUT,
  output logic             PAIR_32BIT_OUT,
  output logic             TIMER_RUN_OUT,
  output logic             IRQ_OUT
);

  // ****************************************
  // bus decode
  // ****************************************
  avs_req_t    req;
  logic        ack_q;
  logic        bus_req;
  logic        acc;
  logic        sel_ctrl;
  logic        sel_stat;
  logic        sel_mask;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_mask;
  logic [31:0] wmask_be;
  logic [31:0] rd_mux;
  logic [31:0] readdata_q;

  assign req = '{addr:  AVS_ADDRESS_IN,
                 rd:    AVS_READ_IN,
                 wr:    AVS_WRITE_IN,
                 wdata: AVS_WRITEDATA_IN,
                 be:    AVS_BYTEENABLE_IN};

  // one wait state: read data is fetched in the first cycle
  assign bus_req  = req.rd | req.wr;
  assign AVS_WAITREQUEST_OUT = bus_req & ~ack_q;
  assign acc      = bus_req & ack_q;
  assign sel_ctrl = (req.addr == `TMR_CTRL_OFS);
  assign sel_stat = (req.addr == `TMR_STAT_OFS);
  assign sel_mask = (req.addr == `TMR_MASK_OFS);
  assign wr_ctrl  = acc & req.wr & sel_ctrl;
  assign wr_stat  = acc & req.wr & sel_stat & req.be[0];
  assign wr_mask  = acc & req.wr & sel_mask & req.be[0];
  assign wmask_be = {{8{req.be[3]}}, {8{req.be[2]}},
                     {8{req.be[1]}}, {8{req.be[0]}}};

  // ****************************************
  // control register
  // ****************************************
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  ctrl_t       cfg;

  // only implemented fields can ever become set
  assign ctrl_d = wr_ctrl ?
    ((ctrl_q & ~wmask_be[15:0]) |
     (req.wdata[15:0] & wmask_be[15:0])) & `TMR_CTRL_WMASK :
    ctrl_q;

  assign cfg = '{timer_on:               ctrl_q[`TMR_ON_BIT],
                 stop_in_idle:           ctrl_q[`TMR_SIDL_BIT],
                 gate_accumulate_enable: ctrl_q[`TMR_GATE_BIT],
                 input_prescale_select:
                   prescale_t'(ctrl_q[`TMR_PS_HI:`TMR_PS_LO]),
                 pair_32bit_select:      ctrl_q[`TMR_PAIR_BIT],
                 clock_source_select:    ctrl_q[`TMR_CS_BIT]};

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ctrl_q <= `TMR_CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ****************************************
  // count source selection
  // ****************************************
  logic       pin_prev_q;
  logic       pin_rise;
  logic       pin_fall;
  logic       gate_en;
  logic       running;
  logic       src_ev;
  logic [7:0] ps_lim;
  logic [7:0] ps_cnt_q;
  logic [7:0] ps_cnt_d;
  logic       tick_d;
  logic       tick_q;

  assign pin_rise = EXTERNAL_TIMER_CLOCK_PIN_IN & ~pin_prev_q;
  assign pin_fall = ~EXTERNAL_TIMER_CLOCK_PIN_IN & pin_prev_q;

  // gate is meaningless with the pin as the clock
  assign gate_en = cfg.gate_accumulate_enable &
                   ~cfg.clock_source_select;

  assign running = cfg.timer_on &
                   ~(IDLE_MODE_IN & cfg.stop_in_idle);

  assign src_ev = cfg.clock_source_select ? pin_rise :
                  gate_en ? EXTERNAL_TIMER_CLOCK_PIN_IN :
                  1'b1;

  always_comb begin
    unique case (cfg.input_prescale_select)
      PS_1:   ps_lim = `TMR_PS1_LIM;
      PS_8:   ps_lim = `TMR_PS8_LIM;
      PS_64:  ps_lim = `TMR_PS64_LIM;
      PS_256: ps_lim = `TMR_PS256_LIM;
    endcase
  end

  // the prescaler holds at zero while stopped, so a restart
  // always begins a fresh division period
  always_comb begin
    ps_cnt_d = ps_cnt_q;
    tick_d   = 1'b0;
    if (!running) begin
      ps_cnt_d = 8'h00;
    end else if (src_ev) begin
      if (ps_cnt_q >= ps_lim) begin
        ps_cnt_d = 8'h00;
        tick_d   = 1'b1;
      end else begin
        ps_cnt_d = ps_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pin_prev_q <= 1'b0;
      ps_cnt_q   <= 8'h00;
      tick_q     <= 1'b0;
    end else begin
      pin_prev_q <= EXTERNAL_TIMER_CLOCK_PIN_IN;
      ps_cnt_q   <= ps_cnt_d;
      tick_q     <= tick_d;
    end
  end

  assign LOWER_TICK_OUT = tick_q;
  assign PAIR_32BIT_OUT = cfg.pair_32bit_select;
  assign TIMER_RUN_OUT  = cfg.timer_on;

  // ****************************************
  // events, status and mask
  // ****************************************
  logic [2:0] evt_set;
  logic [2:0] stat_q;
  logic [2:0] stat_d;
  logic [2:0] mask_q;
  logic       gate_end;

  assign gate_end = running & gate_en & pin_fall;

  // paired timer reports on the upper flag instead of the lower one
  assign evt_set[`TMR_EVT_LOWER] = ~cfg.pair_32bit_select &
                                   (PERIOD_MATCH_IN | gate_end);
  assign evt_set[`TMR_EVT_UPPER] = cfg.pair_32bit_select ?
                                   (PERIOD_MATCH_IN | gate_end) :
                                   UPPER_MATCH_IN;
  assign evt_set[`TMR_EVT_GATE]  = gate_end;

  // a new event wins over a write-one-to-clear
  assign stat_d = (stat_q & ~(wr_stat ? req.wdata[2:0] : 3'h0))
                  | evt_set;

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      stat_q <= `TMR_EVT_RST;
      mask_q <= `TMR_EVT_RST;
    end else begin
      stat_q <= stat_d;
      mask_q <= wr_mask ? req.wdata[2:0] : mask_q;
    end
  end

  assign IRQ_OUT = |(stat_q & mask_q);

  // ****************************************
  // read path
  // ****************************************
  assign rd_mux = sel_ctrl ? {16'h0000, ctrl_q} :
                  sel_stat ? {29'h0, stat_q} :
                  sel_mask ? {29'h0, mask_q} :
                  32'h0000_0000;

  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ack_q      <= 1'b0;
      readdata_q <= 32'h0000_0000;
    end else begin
      ack_q      <= bus_req & ~ack_q;
      readdata_q <= (req.rd & ~ack_q) ? rd_mux : readdata_q;
    end
  end

  assign AVS_READDATA_OUT = readdata_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  logic free_int;
  logic free8;

  assign free_int = running & ~cfg.clock_source_select & ~gate_en;
  assign free8    = free_int & (cfg.input_prescale_select == PS_8);

  a_idle_halt_tick: assert property (
    IDLE_MODE_IN && cfg.stop_in_idle |=> !LOWER_TICK_OUT)
    else $error("tick while halted in idle");

  // keep-run check names its inputs directly so a broken idle term cannot hide it
  a_idle_keep_run: assert property (
    cfg.timer_on && IDLE_MODE_IN && !cfg.stop_in_idle &&
    !cfg.clock_source_select && !cfg.gate_accumulate_enable &&
    cfg.input_prescale_select == PS_1 |=> LOWER_TICK_OUT)
    else $error("idle without stop bit halted timer");

  a_gate_low_hold: assert property (
    running && gate_en && !EXTERNAL_TIMER_CLOCK_PIN_IN
    |=> !LOWER_TICK_OUT)
    else $error("tick with gate closed");

  a_gate_end_flag: assert property (
    gate_end |=> stat_q[`TMR_EVT_GATE])
    else $error("gate end not flagged");

  a_ps8_period: assert property (
    (LOWER_TICK_OUT && free8) ##1 free8[*7] |=> LOWER_TICK_OUT)
    else $error("divide by 8 late");

  a_ps8_quiet: assert property (
    (LOWER_TICK_OUT && free8) ##1 free8 |-> !LOWER_TICK_OUT)
    else $error("divide by 8 early");

  a_pair_follow: assert property (
    wr_ctrl && req.be[0] |=>
    PAIR_32BIT_OUT == $past(req.wdata[`TMR_PAIR_BIT]))
    else $error("pairing output not updated");

  a_ext_edge_tick: assert property (
    running && cfg.clock_source_select && pin_rise &&
    cfg.input_prescale_select == PS_1 |=> LOWER_TICK_OUT)
    else $error("pin edge not counted");

  a_ext_no_edge: assert property (
    cfg.clock_source_select && !pin_rise |=> !LOWER_TICK_OUT)
    else $error("count without pin edge");

  a_off_no_tick: assert property (
    !cfg.timer_on |=> !LOWER_TICK_OUT)
    else $error("tick while off");

  a_pair_irq_route: assert property (
    PERIOD_MATCH_IN && cfg.pair_32bit_select
    |=> stat_q[`TMR_EVT_UPPER])
    else $error("paired match missed upper flag");

  a_rsvd_read_zero: assert property (
    acc && req.rd && sel_ctrl |=>
    (AVS_READDATA_OUT & ~{16'h0000, `TMR_CTRL_WMASK}) == 32'h0)
    else $error("reserved control bit reads one");

  c_paired_match: cover property (
    cfg.pair_32bit_select && PERIOD_MATCH_IN ##1 IRQ_OUT);
  c_gated_end: cover property (gate_end);
  c_ext_tick: cover property (
    cfg.clock_source_select && LOWER_TICK_OUT);
  c_ps256_tick: cover property (
    cfg.input_prescale_select == PS_256 && LOWER_TICK_OUT);
  c_idle_keep: cover property (
    IDLE_MODE_IN && !cfg.stop_in_idle && LOWER_TICK_OUT);

endmodule : timer2_control

// ===== common/timer2_cfg.svh
`ifndef TIMER2_CFG_SVH
`define TIMER2_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define TMR_CTRL_OFS   4'h0
`define TMR_STAT_OFS   4'h4
`define TMR_MASK_OFS   4'h8

// ****************************************
// control field positions
// ****************************************
`define TMR_ON_BIT     15
`define TMR_SIDL_BIT   13
`define TMR_GATE_BIT   6
`define TMR_PS_HI      5
`define TMR_PS_LO      4
`define TMR_PAIR_BIT   3
`define TMR_CS_BIT     1

// ****************************************
// reset values and masks
// ****************************************
`define TMR_CTRL_RST   16'h0000
`define TMR_CTRL_WMASK 16'ha07a
`define TMR_EVT_RST    3'h0

// ****************************************
// status and mask bit positions
// ****************************************
`define TMR_EVT_LOWER  0
`define TMR_EVT_UPPER  1
`define TMR_EVT_GATE   2

// ****************************************
// prescale terminal counts
// ****************************************
`define TMR_PS1_LIM    8'h00
`define TMR_PS8_LIM    8'h07
`define TMR_PS64_LIM   8'h3f
`define TMR_PS256_LIM  8'hff

`endif

// ===== common/timer2_pkg.sv
package timer2_pkg;

  typedef enum logic [1:0] {
    PS_1   = 2'b00,
    PS_8   = 2'b01,
    PS_64  = 2'b10,
    PS_256 = 2'b11
  } prescale_t;

  typedef struct packed {
    logic      timer_on;
    logic      stop_in_idle;
    logic      gate_accumulate_enable;
    prescale_t input_prescale_select;
    logic      pair_32bit_select;
    logic      clock_source_select;
  } ctrl_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [3:0]  be;
  } avs_req_t;

endpackage : timer2_pkg

// ===== verif/testbench.sv
`timescale 1ns/100ps
`include "timer2_cfg.svh"

module testbench;
  import timer2_pkg::*;

  logic        clk = 0, rst_n = 0, rd = 0, wr = 0, pin = 0, idle = 0, pm = 0, um = 0;
  logic [3:0]  addr = 4'h0, be = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic        wreq, tick, pair, run, irq;
  int          num_errors = 0, cmp_count = 0, cycles = 0;
  int          sh[4] = '{0, 3, 6, 8};

  always #2 clk = ~clk;

  timer2_control dut_u (
    .CORE_CLK_IN                 (clk),
    .RESET_N_IN                  (rst_n),
    .AVS_ADDRESS_IN              (addr),
    .AVS_READ_IN                 (rd),
    .AVS_WRITE_IN                (wr),
    .AVS_WRITEDATA_IN            (wdata),
    .AVS_BYTEENABLE_IN           (be),
    .AVS_READDATA_OUT            (rdata),
    .AVS_WAITREQUEST_OUT         (wreq),
    .EXTERNAL_TIMER_CLOCK_PIN_IN (pin),
    .IDLE_MODE_IN                (idle),
    .PERIOD_MATCH_IN             (pm),
    .UPPER_MATCH_IN              (um),
    .LOWER_TICK_OUT              (tick),
    .PAIR_32BIT_OUT              (pair),
    .TIMER_RUN_OUT               (run),
    .IRQ_OUT                     (irq)
  );

  // ****************************************
  // reporting
  // ****************************************
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // hang guard: all tests fit well inside this many cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  // ****************************************
  // bus access
  // ****************************************
  task wr_reg(input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    be    <= b;
    wr    <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    do @(posedge clk); while (wreq !== 1'b0);
    d = rdata;
    rd <= 1'b0;
  endtask : rd_reg

  function automatic logic [31:0] cv(logic on, logic sidl, logic gate, logic [1:0] ps,
                                     logic pr, logic cs);
    cv = {16'h0, on, 1'b0, sidl, 6'h0, gate, ps, pr, 1'b0, cs, 1'b0};
  endfunction : cv

  // pin mode 0 low, 1 high, 2 toggles with a rising edge every 4 cycles;
  // 16 warm-up cycles let the prescaler reach steady state before counting
  task ticks(input int n, input int mode, input int exp);
    int c;
    c = 0;
    for (int i = 0; i < n + 16; i++) begin
      pin <= (mode == 2) ? i[1] : mode[0];
      @(posedge clk);
      if (i >= 16 && tick === 1'b1)
        c++;
    end
    chk(c, exp, "tick count");
  endtask : ticks

  task pulse(input logic upper);
    if (upper)
      um <= 1'b1;
    else
      pm <= 1'b1;
    @(posedge clk);
    um <= 1'b0;
    pm <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(`TMR_CTRL_OFS, rv); chk(rv, 32'h0, "ctrl reset");
    rd_reg(`TMR_STAT_OFS, rv); chk(rv, 32'h0, "status reset");
    wr_reg(`TMR_CTRL_OFS, 32'hffffffff, 4'hf);
    rd_reg(`TMR_CTRL_OFS, rv); chk(rv, 32'h0000a07a, "ctrl mask");
    chk(pair, 1'b1, "pair on");
    chk(run, 1'b1, "run on");
    rd_reg(4'hc, rv); chk(rv, 32'h0, "unmapped");
    wr_reg(`TMR_CTRL_OFS, cv(0, 0, 0, 0, 0, 0), 4'h3);
    @(negedge clk);
    chk(pair, 1'b0, "pair off");
    chk(run, 1'b0, "run off");
    $display("test registers done");
    for (int p = 0; p < 4; p++) begin
      wr_reg(`TMR_CTRL_OFS, cv(1, 0, 0, p[1:0], 0, 0), 4'h3);
      ticks(512, 0, 512 >> sh[p]);
    end
    $display("test prescale done");
    wr_reg(`TMR_CTRL_OFS, cv(1, 0, 1, 0, 0, 0), 4'h3);
    ticks(64, 1, 64);
    ticks(64, 0, 0);
    rd_reg(`TMR_STAT_OFS, rv); chk(rv, 32'h5, "gate end flags");
    wr_reg(`TMR_CTRL_OFS, cv(1, 0, 0, 0, 0, 0), 4'h3);
    ticks(64, 0, 64);
    wr_reg(`TMR_CTRL_OFS, cv(1, 0, 1, 0, 0, 1), 4'h3);
    ticks(64, 2, 16);
    wr_reg(`TMR_CTRL_OFS, cv(1, 0, 0, 1, 0, 1), 4'h3);
    ticks(256, 2, 8);
    $display("test source and gate done");
    idle <= 1'b1;
    wr_reg(`TMR_CTRL_OFS, cv(1, 1, 0, 0, 0, 0), 4'h3);
    ticks(64, 0, 0);
    wr_reg(`TMR_CTRL_OFS, cv(1, 0, 0, 0, 0, 0), 4'h3);
    ticks(64, 0, 64);
    idle <= 1'b0;
    wr_reg(`TMR_CTRL_OFS, cv(1, 1, 0, 0, 0, 0), 4'h3);
    ticks(64, 0, 64);
    wr_reg(`TMR_CTRL_OFS, cv(0, 0, 0, 0, 0, 0), 4'h3);
    ticks(64, 0, 0);
    $display("test idle and on done");
    wr_reg(`TMR_STAT_OFS, 32'h7, 4'h1);
    wr_reg(`TMR_MASK_OFS, 32'h7, 4'h1);
    wr_reg(`TMR_CTRL_OFS, cv(0, 0, 0, 0, 1, 0), 4'h3);
    pulse(0);
    rd_reg(`TMR_STAT_OFS, rv); chk(rv, 32'h2, "paired flag");
    chk(irq, 1'b1, "irq paired");
    wr_reg(`TMR_STAT_OFS, 32'h2, 4'h1);
    @(negedge clk);
    chk(irq, 1'b0, "irq cleared");
    pulse(1);
    rd_reg(`TMR_STAT_OFS, rv); chk(rv, 32'h0, "upper ignored");
    wr_reg(`TMR_CTRL_OFS, cv(0, 0, 0, 0, 0, 0), 4'h3);
    pulse(0);
    rd_reg(`TMR_STAT_OFS, rv); chk(rv, 32'h1, "lower flag");
    wr_reg(`TMR_MASK_OFS, 32'h0, 4'h1);
    @(negedge clk);
    chk(irq, 1'b0, "irq masked");
    wr_reg(`TMR_MASK_OFS, 32'h1, 4'h1);
    @(negedge clk);
    chk(irq, 1'b1, "irq unmasked");
    $display("test interrupts done");
    final_report();
  end
endmodule : testbench
